//--- tb/adc_host.sv
`default_nettype none
module adc_host
    import adc_serial_pkg::*;
(
    // Clock
    input  wire logic CLK,
    // Link pins
    output logic      CS_N, SCLK, DIN,
    input  wire logic DOUT_O, DOUT_OE, STRB_O
);
    timeunit 1ns;
    timeprecision 100ps;
    logic last_ff = 1'b0;
    // Released line shows inverse of last level
    wire  dout_w = DOUT_OE ? DOUT_O : ~last_ff;
    always @(posedge CLK) if (DOUT_OE) last_ff <= DOUT_O;
    initial begin
        CS_N = 1'b1;
        SCLK = 1'b0;
        DIN  = 1'b0;
    end
    task automatic half();
        repeat (16) @(posedge CLK);
    endtask : half
    task automatic xfer(input logic [7:0] ctl, input int lz, input int n,
                        input logic sel, output logic [15:0] rx);
        rx = '0;
        CS_N <= ~sel;
        half();
        for (int i = 0; i < lz + 8 + n; i++) begin
            DIN <= (i >= lz && i < lz + 8) ? ctl[lz + 7 - i] : ~sel;
            half();
            SCLK <= 1'b1;
            if (i >= lz + 8) rx = {rx[14:0], dout_w};
            half();
            SCLK <= 1'b0;
            if (sel && i == lz + 7 && ctl[1:0] != PM_EXT_CLOCK) begin
                half();
                for (int k = 0; k < 2000 && STRB_O !== 1'b1; k++)
                    @(posedge CLK);
            end
        end
        half();
        CS_N <= 1'b1;
        half();
    endtask : xfer
endmodule : adc_host
`default_nettype wire

//--- tb/adc_if_chk_sva.sv
`default_nettype none
module adc_if_chk
    import adc_serial_pkg::*;
#(parameter int FIFO_DEPTH = 8) (
    input wire logic       CLK, RESET, CE, CS_N, SCLK,
    input wire logic       DOUT_O, DOUT_OE, STRB_O, STRB_OE,
    input wire logic [1:0] SHUTDOWN_LEVEL_INPUT,
    input wire logic       TRACK, SHUTDOWN, EXT_COMP,
    input wire logic [7:0] CONTROL_BYTE
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking @(posedge CLK); endclocking
    default disable iff (RESET || !CE);
    wire ext = CONTROL_BYTE[1:0] == PM_EXT_CLOCK;
    // Cycles the strobe has been low in internal mode
    logic [11:0] low_cnt;
    always_ff @(posedge CLK) begin
        if (RESET || STRB_O || ext) begin
            low_cnt <= 12'h000;
        end else if (CE && low_cnt != 12'hFFF) begin
            low_cnt <= low_cnt + 12'h001;
        end
    end
    a_dout_off_desel: assert property (CS_N [*5] |-> !DOUT_OE)
        else $error("dout driven deselected");
    a_strb_off_ext: assert property (CS_N [*5] ##0 ext |-> !STRB_OE)
        else $error("strobe driven deselected");
    a_ctl_hold: assert property (CS_N [*5] |=> $stable(CONTROL_BYTE))
        else $error("control byte moved");
    a_dout_on_fall: assert property ($changed(DOUT_O) && DOUT_OE |-> !SCLK)
        else $error("dout moved, clock high");
    a_strb_on_fall: assert property ($changed(STRB_O) && ext |-> !SCLK)
        else $error("strobe moved, clock high");
    a_strb_ext_width: assert property ($rose(STRB_O) && ext
        |-> STRB_O [*8] ##[21:29] $fell(STRB_O)) else $error("pulse width");
    a_strb_int_time: assert property ($rose(STRB_O) && !ext
        |-> low_cnt >= 12'h5D2 && low_cnt <= 12'h5E6)
        else $error("busy time");
    a_track_span: assert property ($rose(TRACK)
        |=> TRACK [*8] ##[85:89] $fell(TRACK)) else $error("track span");
    a_shutdown_level_input_low: assert property ((SHUTDOWN_LEVEL_INPUT == SHUTDOWN_LEVEL_INPUT_LOW) [*5]
        |-> SHUTDOWN) else $error("shutdown low");
    a_shutdown_level_input_float: assert property ((SHUTDOWN_LEVEL_INPUT == SHUTDOWN_LEVEL_INPUT_FLOAT) [*5]
        |-> EXT_COMP && !SHUTDOWN) else $error("shutdown float");
endmodule : adc_if_chk
bind serial_adc_if adc_if_chk #(.FIFO_DEPTH(FIFO_DEPTH)) u_chk (
    .CLK(CLK), .RESET(RESET), .CE(CE), .CS_N(CS_N), .SCLK(SCLK),
    .DOUT_O(DOUT_O), .DOUT_OE(DOUT_OE), .STRB_O(STRB_O),
    .STRB_OE(STRB_OE), .SHUTDOWN_LEVEL_INPUT(SHUTDOWN_LEVEL_INPUT),
    .TRACK(TRACK), .SHUTDOWN(SHUTDOWN), .EXT_COMP(EXT_COMP),
    .CONTROL_BYTE(CONTROL_BYTE));
`default_nettype wire

//--- tb/serial_adc_if_tb.sv
`default_nettype none
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin errors++; \
    $display("[ERR] %0t got %h want %h", $time, a, b); end end
module serial_adc_if_tb
    import adc_serial_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    logic                   CLK, RESET, RES_READY;
    wire                    CS_N, SCLK, DIN;
    logic                   DOUT_O, DOUT_OE, STRB_O, STRB_OE, TRACK;
    logic                   CONVERTING, SHUTDOWN, EXT_COMP, RES_VALID;
    logic [1:0]             shutdown_level_input;
    logic [RESULT_BITS-1:0] sample, RES_DATA;
    logic [7:0]             CONTROL_BYTE;
    logic [15:0]            rx;
    int                     errors = 0;
    int                     tests_run = 0;
    serial_adc_if #(.FIFO_DEPTH(8)) DUT (
        .CLK(CLK), .RESET(RESET), .CE(1'b1), .CS_N(CS_N), .SCLK(SCLK),
        .DIN(DIN), .DOUT_O(DOUT_O), .DOUT_OE(DOUT_OE), .STRB_O(STRB_O),
        .STRB_OE(STRB_OE), .SHUTDOWN_LEVEL_INPUT(shutdown_level_input),
        .SAMPLE_DATA(sample), .TRACK(TRACK), .CONVERTING(CONVERTING),
        .CONTROL_BYTE(CONTROL_BYTE), .SHUTDOWN(SHUTDOWN),
        .EXT_COMP(EXT_COMP), .RES_VALID(RES_VALID),
        .RES_DATA(RES_DATA), .RES_READY(RES_READY));
    adc_host host (.CLK(CLK), .CS_N(CS_N), .SCLK(SCLK), .DIN(DIN),
        .DOUT_O(DOUT_O), .DOUT_OE(DOUT_OE), .STRB_O(STRB_O));
    task automatic stop_test();
        $display("checks %0d errors %0d", tests_run, errors);
        if (errors == 0 && tests_run > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : stop_test
    task automatic pop(input logic [RESULT_BITS-1:0] exp);
        for (int k = 0; k < 64 && RES_VALID !== 1'b1; k++) @(posedge CLK);
        `CHK(RES_VALID, 1'b1)
        `CHK(RES_DATA, exp)
        RES_READY <= 1'b1;
        @(posedge CLK);
        RES_READY <= 1'b0;
        @(posedge CLK);
    endtask : pop
    task automatic conv(input logic [7:0] ctl, input int lz,
                        input logic [RESULT_BITS-1:0] d);
        sample <= d;
        // Internal mode puts one leading zero before the result
        host.xfer(ctl, lz, (ctl[1:0] == PM_EXT_CLOCK) ? 11 : 12, 1'b1, rx);
        `CHK(CONTROL_BYTE, ctl)
        `CHK(rx[9:0], d)
    endtask : conv
    initial begin
        CLK = 1'b0;
        forever #2.5 CLK = ~CLK;
    end
    initial begin
        repeat (40000) @(posedge CLK);
        errors++;
        stop_test();
    end
    initial begin
        RESET = 1'b1;
        RES_READY = 1'b0;
        shutdown_level_input = SHUTDOWN_LEVEL_INPUT_HIGH;
        sample = '0;
        repeat (8) @(posedge CLK);
        RESET <= 1'b0;
        repeat (4) @(posedge CLK);
        conv(8'hFF, 3, 10'h2A5);
        pop(10'h2A5);
        $display("test ext done");
        conv(8'hF6, 0, 10'h1C3);
        pop(10'h1C3);
        $display("test int done");
        host.xfer(8'hFF, 0, 4, 1'b0, rx);
        `CHK(CONTROL_BYTE, 8'hF6)
        `CHK(RES_VALID, 1'b0)
        $display("test deselect done");
        for (int i = 0; i < 3; i++) begin
            shutdown_level_input <= 2'(i);
            repeat (8) @(posedge CLK);
            `CHK(SHUTDOWN, i == 0)
            `CHK(EXT_COMP, i == 1)
        end
        $display("test shutdown done");
        for (int i = 0; i < 9; i++)
            conv({1'b1, 3'(i), 4'hF}, 0, 10'h100 + 10'(i));
        `CHK(RES_VALID, 1'b1)
        for (int i = 0; i < 8; i++) pop(10'h100 + 10'(i));
        repeat (4) @(posedge CLK);
        `CHK(RES_VALID, 1'b0)
        $display("test fifo done");
        stop_test();
    end
endmodule : serial_adc_if_tb
`default_nettype wire

//--- verilog/adc_serial_pkg.sv
`default_nettype none
package adc_serial_pkg;
    // Control byte fields, MSB first
    localparam int CTL_START_POS  = 7;
    localparam int CTL_SEL_HI_POS = 6;
    localparam int CTL_SEL_LO_POS = 4;
    localparam int CTL_POL_POS    = 3;
    localparam int CTL_CFG_POS    = 2;
    localparam int CTL_PM_HI_POS  = 1;
    localparam int CTL_PM_LO_POS  = 0;
    localparam logic [1:0] PM_EXT_CLOCK = 2'h3;
    // Sampling window in control bits
    localparam logic [3:0] TRACK_BIT    = 4'h5;
    localparam logic [3:0] HOLD_BIT     = 4'h8;
    // Conversion length and result width
    localparam int RESULT_BITS          = 10;
    localparam logic [3:0] CONV_CLOCKS  = 4'hA;
    // Internal-clock conversion time
    localparam int CLK_MHZ              = 200;
    localparam int INT_CONV_NS          = 7500;
    localparam int INT_CONV_CYC = (INT_CONV_NS * CLK_MHZ) / 1000;
    // Shutdown pin levels
    localparam logic [1:0] SHUTDOWN_LEVEL_INPUT_LOW     = 2'h0;
    localparam logic [1:0] SHUTDOWN_LEVEL_INPUT_FLOAT   = 2'h1;
    localparam logic [1:0] SHUTDOWN_LEVEL_INPUT_HIGH    = 2'h2;
    localparam logic [7:0] CTL_RESET    = 8'h00;

    typedef struct packed {
        logic [2:0] channel;
        logic       polarity_select;
        logic       input_config_select;
        logic       power_mode_hi;
        logic       power_mode_lo;
    } ctl_t;

    typedef enum logic [2:0] {
        ST_IDLE  = 3'b000,
        ST_CTRL  = 3'b001,
        ST_ICONV = 3'b010,
        ST_XSTRB = 3'b011,
        ST_XCONV = 3'b100,
        ST_SHIFT = 3'b101
    } state_t;
endpackage : adc_serial_pkg
`default_nettype wire

//--- verilog/result_fifo.sv
`default_nettype none
module result_fifo #(
    parameter int WIDTH = 10,
    parameter int DEPTH = 8
) (
    input  wire logic             clk,
    input  wire logic             reset,
    input  wire logic             ce,
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic      [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0]    wr_ff;
    logic [AW-1:0]    rd_ff;
    logic [AW:0]      cnt_ff;
    wire              push = ce && in_valid && in_ready;
    wire              pop  = ce && out_valid && out_ready;

    assign in_ready  = (cnt_ff != (AW+1)'(DEPTH));
    assign out_valid = (cnt_ff != '0);
    assign out_data  = mem[rd_ff];

    always_ff @(posedge clk) begin
        if (push) begin
            mem[wr_ff] <= in_data;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            wr_ff  <= '0;
            rd_ff  <= '0;
            cnt_ff <= '0;
        end else begin
            if (push) begin
                wr_ff <= (wr_ff == AW'(DEPTH-1)) ? '0 : wr_ff + 1'b1;
            end
            if (pop) begin
                rd_ff <= (rd_ff == AW'(DEPTH-1)) ? '0 : rd_ff + 1'b1;
            end
            cnt_ff <= cnt_ff + (AW+1)'(push) - (AW+1)'(pop);
        end
    end
endmodule : result_fifo
`default_nettype wire

//--- verilog/serial_adc_if.sv
`default_nettype none
module serial_adc_if
    import adc_serial_pkg::*;
#(
    parameter int FIFO_DEPTH = 8
) (
    // Clock, reset, enable
    input  wire logic                   CLK,
    input  wire logic                   RESET,
    input  wire logic                   CE,
    // Serial link pins
    input  wire logic                   CS_N,
    input  wire logic                   SCLK,
    input  wire logic                   DIN,
    output logic                        DOUT_O,
    output logic                        DOUT_OE,
    output logic                        STRB_O,
    output logic                        STRB_OE,
    // Shutdown pin level, 0 low, 1 float, 2 high
    input  wire logic [1:0]             SHUTDOWN_LEVEL_INPUT,
    // Converter core side
    input  wire logic [RESULT_BITS-1:0] SAMPLE_DATA,
    output logic                        TRACK,
    output logic                        CONVERTING,
    output logic [7:0]                  CONTROL_BYTE,
    output logic                        SHUTDOWN,
    output logic                        EXT_COMP,
    // Result stream
    output logic                        RES_VALID,
    output logic [RESULT_BITS-1:0]      RES_DATA,
    input  wire logic                   RES_READY
);
    // Two-stage synchronisers
    logic [2:0] cs_s1_ff, cs_s2_ff, cs_d_ff;
    logic [1:0] sh_s1_ff, sh_s2_ff;
    always_ff @(posedge CLK) begin
        if (RESET) begin
            cs_s1_ff <= 3'h1;
            cs_s2_ff <= 3'h1;
            cs_d_ff  <= 3'h1;
            sh_s1_ff <= SHUTDOWN_LEVEL_INPUT_HIGH;
            sh_s2_ff <= SHUTDOWN_LEVEL_INPUT_HIGH;
        end else if (CE) begin
            cs_s1_ff <= {DIN, SCLK, CS_N};
            cs_s2_ff <= cs_s1_ff;
            cs_d_ff  <= cs_s2_ff;
            sh_s1_ff <= SHUTDOWN_LEVEL_INPUT;
            sh_s2_ff <= sh_s1_ff;
        end
    end

    wire sel     = !cs_s2_ff[0];
    wire din_s   = cs_s2_ff[2];
    wire rise    = CE && sel && cs_s2_ff[1] && !cs_d_ff[1];
    wire fall    = CE && sel && !cs_s2_ff[1] && cs_d_ff[1];
    wire cs_fall = CE && sel && cs_d_ff[0];

    state_t            st_ff, nxt_st;
    logic [7:0]        sh_ff;
    logic [3:0]        bits_ff;
    logic [3:0]        cnt_ff;
    logic [15:0]       icnt_ff;
    logic [RESULT_BITS+1:0] out_ff;
    logic              ext_ff;
    logic              dout_ff, strb_ff, strb_oe_ff, dout_oe_ff;
    logic              track_ff, conv_ff, shut_ff, comp_ff;
    logic [7:0]        ctl_ff;
    logic              push_ff;
    logic [RESULT_BITS-1:0] push_data_ff;

    wire  ctl_done  = rise && st_ff == ST_CTRL && bits_ff == 4'h7;
    wire  ext_mode  = {sh_ff[0], din_s} == PM_EXT_CLOCK;
    wire  ictl_end  = icnt_ff == 16'(INT_CONV_CYC - 1);
    wire  fifo_rdy;

    always_comb begin
        nxt_st = st_ff;
        case (st_ff)
            ST_IDLE:  if (rise && din_s) nxt_st = ST_CTRL;
            ST_CTRL:  if (ctl_done) nxt_st = ext_mode ? ST_XSTRB : ST_ICONV;
            ST_ICONV: if (ictl_end && CE && fifo_rdy) nxt_st = ST_SHIFT;
            ST_XSTRB: if (fall && cnt_ff == 4'h1) nxt_st = ST_XCONV;
            ST_XCONV: if (fall && cnt_ff == CONV_CLOCKS - 4'h1) begin
                          nxt_st = ST_IDLE;
                      end
            ST_SHIFT: if (rise && din_s) nxt_st = ST_CTRL;
            default:  nxt_st = ST_IDLE;
        endcase
        if (!sel) nxt_st = ST_IDLE;
    end

    always_ff @(posedge CLK) begin
        if (RESET) begin
            st_ff <= ST_IDLE;
            sh_ff <= CTL_RESET;
            bits_ff <= 4'h0;
            cnt_ff <= 4'h0;
            icnt_ff <= 16'h0;
            out_ff <= '0;
            ext_ff <= 1'b0;
            dout_ff <= 1'b0;
            dout_oe_ff <= 1'b0;
            strb_ff <= 1'b1;
            strb_oe_ff <= 1'b1;
            track_ff <= 1'b0;
            conv_ff <= 1'b0;
            shut_ff <= 1'b0;
            comp_ff <= 1'b0;
            ctl_ff <= CTL_RESET;
            push_ff <= 1'b0;
            push_data_ff <= '0;
        end else if (CE) begin
            st_ff <= nxt_st;
            push_ff <= 1'b0;
            shut_ff <= sh_s2_ff == SHUTDOWN_LEVEL_INPUT_LOW;
            comp_ff <= sh_s2_ff == SHUTDOWN_LEVEL_INPUT_FLOAT;
            dout_oe_ff <= sel;
            // Internal mode always drives; external only while selected
            strb_oe_ff <= !ext_ff || (sel && (strb_oe_ff || cs_fall));
            if (!sel) begin
                track_ff <= 1'b0;
                bits_ff <= 4'h0;
            end
            if (rise && (st_ff == ST_IDLE || st_ff == ST_SHIFT) && din_s) begin
                sh_ff <= 8'h01;
                bits_ff <= 4'h1;
            end else if (rise && st_ff == ST_CTRL) begin
                sh_ff <= {sh_ff[6:0], din_s};
                bits_ff <= bits_ff + 4'h1;
            end
            if (fall && bits_ff == TRACK_BIT) track_ff <= 1'b1;
            if (ctl_done) begin
                ctl_ff <= {sh_ff[6:0], din_s};
                ext_ff <= ext_mode;
                cnt_ff <= 4'h0;
            end
            if (fall && st_ff != ST_CTRL && track_ff) begin
                track_ff <= 1'b0;
            end
            if (st_ff == ST_ICONV) begin
                conv_ff <= 1'b1;
                // Hold at the end while the result waits for room
                icnt_ff <= ictl_end ? icnt_ff : icnt_ff + 16'h1;
                strb_ff <= ictl_end;
                if (ictl_end && fifo_rdy) begin
                    out_ff <= {1'b0, SAMPLE_DATA, 1'b0};
                    push_ff <= 1'b1;
                    push_data_ff <= SAMPLE_DATA;
                    conv_ff <= 1'b0;
                end
            end else begin
                icnt_ff <= 16'h0;
            end
            if (fall) begin
                dout_ff <= out_ff[RESULT_BITS+1];
                out_ff <= {out_ff[RESULT_BITS:0], 1'b0};
                if (st_ff == ST_XSTRB) begin
                    // Phase 0 raises the strobe, phase 1 drops it
                    strb_ff <= (cnt_ff == 4'h0);
                    conv_ff <= 1'b1;
                    cnt_ff <= (cnt_ff == 4'h0) ? 4'h1 : 4'h0;
                    if (cnt_ff == 4'h0) begin
                        out_ff <= {SAMPLE_DATA, 2'h0};
                    end
                end
                if (st_ff == ST_XCONV) begin
                    cnt_ff <= cnt_ff + 4'h1;
                    if (cnt_ff == CONV_CLOCKS - 4'h1) begin
                        conv_ff <= 1'b0;
                        push_ff <= fifo_rdy;
                        push_data_ff <= SAMPLE_DATA;
                    end
                end
            end
            if (!sel) begin
                dout_ff <= 1'b0;
                if (ext_ff) strb_ff <= 1'b0;
            end
        end
    end

    result_fifo #(
        .WIDTH (RESULT_BITS),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .clk       (CLK),
        .reset     (RESET),
        .ce        (CE),
        .in_valid  (push_ff),
        .in_ready  (fifo_rdy),
        .in_data   (push_data_ff),
        .out_valid (RES_VALID),
        .out_ready (RES_READY),
        .out_data  (RES_DATA)
    );

    assign DOUT_O       = dout_ff;
    assign DOUT_OE      = dout_oe_ff;
    assign STRB_O       = strb_ff;
    assign STRB_OE      = strb_oe_ff;
    assign TRACK        = track_ff;
    assign CONVERTING   = conv_ff;
    assign CONTROL_BYTE = ctl_ff;
    assign SHUTDOWN     = shut_ff;
    assign EXT_COMP     = comp_ff;
endmodule : serial_adc_if
`default_nettype wire
